// [hw/fsz_chan_if.sv]
// per-channel signals between the register core and the channel engines
`timescale 1ns/1ps
interface fsz_chan_if;
    import fsz_pkg::*;
    logic                     ce;
    logic signed [FLOW_W-1:0] flow_raw;
    logic signed [FLOW_W-1:0] flow_corr;
    logic signed [FLOW_W-1:0] setpoint;
    logic signed [FLOW_W-1:0] lower;
    logic signed [FLOW_W-1:0] upper;
    fsz_sup_t                 mode;
    logic                     mode_wr;
    logic                     valve_on;
    logic                     relay_en;
    logic                     relay1;
    logic                     relay2;
    logic                     err;
    logic                     hold;
    logic                     below;
    logic                     above;
    logic                     zero_start;
    logic                     zero_done;
    logic                     zero_reject;
    logic signed [FLOW_W-1:0] zero_meas;

    modport ctl (output ce, flow_raw, flow_corr, setpoint, lower, upper, mode, mode_wr, valve_on,
                 relay_en, zero_start,
                 input relay1, relay2, err, hold, below, above, zero_done, zero_reject, zero_meas);
    modport sup (input ce, flow_corr, setpoint, lower, upper, mode, mode_wr, valve_on, relay_en,
                 output relay1, relay2, err, hold, below, above);
    modport zro (input ce, flow_raw, valve_on, zero_start,
                 output zero_done, zero_reject, zero_meas);
endinterface

// [hw/fsz_pkg.sv]
// shared constants, types and saturating arithmetic for flow supervision and zero trim
package fsz_pkg;
    localparam int N_CH      = 4;
    localparam int FLOW_W    = 16;
    localparam int N_SET     = 5;
    localparam int SET_W     = 3;
    localparam int ADDR_W    = 10;
    localparam int CLK_HZ    = 50_000_000;
    localparam int HOLD_MS   = 1000;
    localparam int HOLD_CYC  = CLK_HZ / 1000 * HOLD_MS;
    localparam int ZERO_LOG2 = 4;
    localparam logic signed [FLOW_W-1:0] ZERO_MAX = 16'sh0200;

    // word index layout: bits [7:4] block (0 global, 1..N_CH channel), bits [3:0] register
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_ZERO   = 4'h0;
    localparam logic [3:0] REG_OFFSET = 4'h1;
    localparam logic [3:0] REG_LOWER  = 4'h2;
    localparam logic [3:0] REG_UPPER  = 4'h3;
    localparam logic [3:0] REG_MODE   = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h5;
    localparam logic [3:0] REG_FLOW   = 4'h6;
    localparam logic [3:0] REG_SET0   = 4'h8;

    localparam int CTRL_RELAY_BIT = 0;
    localparam int CTRL_SEL_LSB   = 4;
    localparam logic             RELAY_EN_RST = 1'b0;
    localparam logic [SET_W-1:0] SEL_RST      = 3'h0;

    localparam int ST_ERR  = 0;
    localparam int ST_R1   = 1;
    localparam int ST_R2   = 2;
    localparam int ST_HOLD = 3;
    localparam int ST_LOW  = 4;
    localparam int ST_HIGH = 5;

    typedef enum logic [1:0] {ZS_ARMED, ZS_RUNNING, ZS_COMPLETED, ZS_REJECTED} fsz_zero_t;
    typedef enum logic [1:0] {SUP_OFF, SUP_ABS, SUP_DEV} fsz_sup_t;

    // a + b (or a - b) clipped to the signed range
    function automatic logic signed [FLOW_W-1:0] fsz_add(input logic signed [FLOW_W-1:0] a,
                                                         input logic signed [FLOW_W-1:0] b,
                                                         input logic                     sub);
        logic signed [FLOW_W:0] s;
        s = sub ? ({a[FLOW_W-1], a} - {b[FLOW_W-1], b}) : ({a[FLOW_W-1], a} + {b[FLOW_W-1], b});
        if (s[FLOW_W] != s[FLOW_W-1])
            return s[FLOW_W] ? {1'b1, {(FLOW_W-1){1'b0}}} : {1'b0, {(FLOW_W-1){1'b1}}};
        return s[FLOW_W-1:0];
    endfunction
endpackage

// [hw/fsz_supervise.sv]
// trip limit comparison, start-up hold-off and relay logic for one channel
`timescale 1ns/1ps
module fsz_supervise #(
    parameter int unsigned HOLD = fsz_pkg::HOLD_CYC
) (
    input  wire logic i_clock,
    input  wire logic i_rst,
    fsz_chan_if.sup   ch
);
    import fsz_pkg::*;

    logic [31:0]              hcnt_ff;
    logic                     hold_ff;
    logic                     r1_ff;
    logic                     r2_ff;
    logic                     err_ff;
    logic                     lo_ff;
    logic                     hi_ff;
    logic signed [FLOW_W-1:0] ref_hi;
    logic signed [FLOW_W-1:0] ref_lo;
    logic                     act;
    logic                     below;
    logic                     above;

    always_comb begin
        ref_hi = ch.upper;
        ref_lo = ch.lower;
        if (ch.mode == SUP_DEV) begin
            ref_hi = fsz_add(ch.setpoint, ch.upper, 1'b0);
            ref_lo = fsz_add(ch.setpoint, ch.lower, 1'b1);
        end
    end

    // the cycle of the mode write itself is held off as well, before hold_ff rises
    assign act   = !hold_ff && !ch.mode_wr && (ch.mode != SUP_OFF);
    assign below = act && (ch.flow_corr < ref_lo);
    assign above = act && (ch.flow_corr > ref_hi);

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            hcnt_ff <= '0;
            hold_ff <= 1'b0;
        end else if (ch.ce) begin
            if (ch.mode_wr) begin
                hcnt_ff <= 32'(HOLD - 1);
                hold_ff <= 1'b1;
            end else if (hcnt_ff != '0) begin
                hcnt_ff <= hcnt_ff - 1'b1;
            end else begin
                hold_ff <= 1'b0;
            end
        end
    end

    // relays recomputed every enabled cycle, nothing latches
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            r1_ff  <= 1'b0;
            r2_ff  <= 1'b0;
            err_ff <= 1'b0;
            lo_ff  <= 1'b0;
            hi_ff  <= 1'b0;
        end else if (ch.ce) begin
            err_ff <= below | above;
            lo_ff  <= below;
            hi_ff  <= above;
            unique case (ch.mode)
                SUP_ABS: begin
                    r1_ff <= ch.relay_en & below;
                    r2_ff <= ch.relay_en & above;
                end
                SUP_DEV: begin
                    r1_ff <= ch.relay_en & ch.valve_on;
                    r2_ff <= ch.relay_en & (below | above);
                end
                default: begin
                    r1_ff <= ch.relay_en & ch.valve_on;
                    r2_ff <= 1'b0;
                end
            endcase
        end
    end

    assign ch.relay1 = r1_ff;
    assign ch.relay2 = r2_ff;
    assign ch.err    = err_ff;
    assign ch.hold   = hold_ff;
    assign ch.below  = lo_ff;
    assign ch.above  = hi_ff;
endmodule

// [hw/fsz_top.sv]
// flow supervision and zero trim: register core, offset correction and presets
//
// The register addresses and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
module fsz_top #(
    parameter int          N_CH = fsz_pkg::N_CH,
    parameter int unsigned HOLD = fsz_pkg::HOLD_CYC
) (
    input  wire logic                                         i_clock,
    input  wire logic                                         i_rst,
    input  wire logic                                         i_clk_en,
    input  wire logic [fsz_pkg::ADDR_W-1:0]                   i_avs_address,
    input  wire logic                                         i_avs_read,
    input  wire logic                                         i_avs_write,
    input  wire logic [31:0]                                  i_avs_writedata,
    output logic      [31:0]                                  o_avs_readdata,
    output logic                                              o_avs_waitrequest,
    input  wire logic [N_CH-1:0][fsz_pkg::FLOW_W-1:0]         i_flow_raw,
    input  wire logic [N_CH-1:0]                              i_valve_on,
    output logic      [N_CH-1:0][fsz_pkg::FLOW_W-1:0]         o_flow_corr,
    output logic      [N_CH-1:0][fsz_pkg::FLOW_W-1:0]         o_setpoint,
    output logic      [N_CH-1:0]                              o_relay1,
    output logic      [N_CH-1:0]                              o_relay2,
    output logic      [N_CH-1:0]                              o_sup_err
);
    import fsz_pkg::*;

    logic                     wait_ff;
    logic [31:0]              rdata_ff;
    logic                     relay_en_ff;
    logic [SET_W-1:0]         sel_ff;
    fsz_zero_t                zst_ff    [N_CH];
    logic                     zstart_ff [N_CH];
    logic signed [FLOW_W-1:0] ofs_ff    [N_CH];
    logic signed [FLOW_W-1:0] lo_ff     [N_CH];
    logic signed [FLOW_W-1:0] hi_ff     [N_CH];
    fsz_sup_t                 mode_ff   [N_CH];
    logic                     mwr_ff    [N_CH];
    logic signed [FLOW_W-1:0] preset    [N_CH][N_SET];
    logic signed [FLOW_W-1:0] fcorr_ff  [N_CH];
    logic signed [FLOW_W-1:0] sp_ff     [N_CH];
    logic signed [FLOW_W-1:0] act_sp    [N_CH];

    logic                     zdone     [N_CH];
    logic                     zrej      [N_CH];
    logic signed [FLOW_W-1:0] zmeas     [N_CH];
    logic [5:0]               stat      [N_CH];

    logic                     req;
    logic                     wr_go;
    logic [7:0]               word;
    logic [3:0]               blk;
    logic [3:0]               rsel;
    logic                     is_glb;
    logic                     is_ch;
    logic [3:0]               chn;
    logic [31:0]              nxt_rdata;

    // ---- bus decode
    assign req    = i_avs_read | i_avs_write;
    assign wr_go  = i_avs_write & ~wait_ff & i_clk_en;
    assign word   = i_avs_address[ADDR_W-1:2];
    assign blk    = word[7:4];
    assign rsel   = word[3:0];
    assign chn    = blk - 4'h1;
    assign is_glb = (blk == 4'h0);
    assign is_ch  = (blk != 4'h0) && (32'(blk) <= N_CH);

    // widen a signed value to a bus word
    function automatic logic [31:0] sx(input logic signed [FLOW_W-1:0] v);
        return 32'(v);
    endfunction

    function automatic logic chan_wr(input logic [3:0] r, input int c);
        return wr_go && is_ch && (32'(chn) == c) && (rsel == r);
    endfunction

    // ---- read data selection
    always_comb begin
        nxt_rdata = '0;
        if (is_glb) begin
            if (rsel == REG_CTRL) begin
                nxt_rdata[CTRL_RELAY_BIT] = relay_en_ff;
                nxt_rdata[CTRL_SEL_LSB +: SET_W] = sel_ff;
            end
        end else if (is_ch) begin
            for (int c = 0; c < N_CH; c++) begin
                if (32'(chn) == c) begin
                    unique case (rsel)
                        REG_ZERO:   nxt_rdata = 32'(zst_ff[c]);
                        REG_OFFSET: nxt_rdata = sx(ofs_ff[c]);
                        REG_LOWER:  nxt_rdata = sx(lo_ff[c]);
                        REG_UPPER:  nxt_rdata = sx(hi_ff[c]);
                        REG_MODE:   nxt_rdata = 32'(mode_ff[c]);
                        REG_STATUS: nxt_rdata = 32'(stat[c]);
                        REG_FLOW:   nxt_rdata = sx(fcorr_ff[c]);
                        default: begin
                            for (int s = 0; s < N_SET; s++) begin
                                if (rsel == REG_SET0 + 4'(s))
                                    nxt_rdata = sx(preset[c][s]);
                            end
                        end
                    endcase
                end
            end
        end
    end

    // ---- avalon handshake: waitrequest drops for one cycle per access
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            wait_ff  <= 1'b1;
            rdata_ff <= '0;
        end else if (i_clk_en) begin
            if (req && wait_ff) begin
                wait_ff  <= 1'b0;
                rdata_ff <= i_avs_read ? nxt_rdata : 32'h0;
            end else begin
                wait_ff <= 1'b1;
            end
        end
    end

    // ---- global control
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            relay_en_ff <= RELAY_EN_RST;
            sel_ff      <= SEL_RST;
        end else if (wr_go && is_glb && rsel == REG_CTRL) begin
            relay_en_ff <= i_avs_writedata[CTRL_RELAY_BIT];
            if (32'(i_avs_writedata[CTRL_SEL_LSB +: SET_W]) < N_SET)
                sel_ff <= i_avs_writedata[CTRL_SEL_LSB +: SET_W];
        end
    end

    // ---- zero status and offset, hardware completion wins over writes
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            for (int c = 0; c < N_CH; c++) begin
                zst_ff[c]    <= ZS_ARMED;
                zstart_ff[c] <= 1'b0;
                ofs_ff[c]    <= '0;
            end
        end else if (i_clk_en) begin
            for (int c = 0; c < N_CH; c++) begin
                zstart_ff[c] <= 1'b0;
                if (zdone[c]) begin
                    zst_ff[c] <= zrej[c] ? ZS_REJECTED : ZS_COMPLETED;
                end else if (chan_wr(REG_ZERO, c)) begin
                    if (zst_ff[c] == ZS_ARMED && i_avs_writedata[1:0] == 2'(ZS_RUNNING)) begin
                        zst_ff[c]    <= ZS_RUNNING;
                        zstart_ff[c] <= 1'b1;
                    end else if (zst_ff[c] != ZS_RUNNING && i_avs_writedata[1:0] == 2'(ZS_ARMED)) begin
                        zst_ff[c] <= ZS_ARMED;
                    end
                end
                if (zdone[c] && !zrej[c])
                    ofs_ff[c] <= zmeas[c];
                else if (chan_wr(REG_OFFSET, c))
                    ofs_ff[c] <= i_avs_writedata[FLOW_W-1:0];
            end
        end
    end

    // ---- trip levels and supervision setting
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            for (int c = 0; c < N_CH; c++) begin
                lo_ff[c]   <= '0;
                hi_ff[c]   <= '0;
                mode_ff[c] <= SUP_OFF;
                mwr_ff[c]  <= 1'b0;
            end
        end else if (i_clk_en) begin
            for (int c = 0; c < N_CH; c++) begin
                mwr_ff[c] <= 1'b0;
                if (chan_wr(REG_LOWER, c))
                    lo_ff[c] <= i_avs_writedata[FLOW_W-1:0];
                if (chan_wr(REG_UPPER, c))
                    hi_ff[c] <= i_avs_writedata[FLOW_W-1:0];
                if (chan_wr(REG_MODE, c) && i_avs_writedata[1:0] != 2'h3) begin
                    mode_ff[c] <= fsz_sup_t'(i_avs_writedata[1:0]);
                    mwr_ff[c]  <= 1'b1;
                end
            end
        end
    end

    // ---- preset store
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            for (int c = 0; c < N_CH; c++) begin
                for (int s = 0; s < N_SET; s++)
                    preset[c][s] <= '0;
            end
        end else if (i_clk_en) begin
            for (int c = 0; c < N_CH; c++) begin
                for (int s = 0; s < N_SET; s++) begin
                    if (chan_wr(REG_SET0 + 4'(s), c))
                        preset[c][s] <= i_avs_writedata[FLOW_W-1:0];
                end
            end
        end
    end

    // ---- offset correction toward the controllers
    always_comb begin
        for (int c = 0; c < N_CH; c++)
            act_sp[c] = preset[c][sel_ff];
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            for (int c = 0; c < N_CH; c++) begin
                fcorr_ff[c] <= '0;
                sp_ff[c]    <= '0;
            end
        end else if (i_clk_en) begin
            for (int c = 0; c < N_CH; c++) begin
                fcorr_ff[c] <= fsz_add(i_flow_raw[c], ofs_ff[c], 1'b1);
                sp_ff[c]    <= fsz_add(act_sp[c], ofs_ff[c], 1'b0);
            end
        end
    end

    // ---- channel engines
    for (genvar g = 0; g < N_CH; g++) begin : g_ch
        fsz_chan_if ch ();

        assign ch.ce         = i_clk_en;
        assign ch.flow_raw   = i_flow_raw[g];
        assign ch.flow_corr  = fcorr_ff[g];
        assign ch.setpoint   = act_sp[g];
        assign ch.lower      = lo_ff[g];
        assign ch.upper      = hi_ff[g];
        assign ch.mode       = mode_ff[g];
        assign ch.mode_wr    = mwr_ff[g];
        assign ch.valve_on   = i_valve_on[g];
        assign ch.relay_en   = relay_en_ff;
        assign ch.zero_start = zstart_ff[g];

        assign zdone[g] = ch.zero_done;
        assign zrej[g]  = ch.zero_reject;
        assign zmeas[g] = ch.zero_meas;
        assign stat[g]  = {ch.above, ch.below, ch.hold, ch.relay2, ch.relay1, ch.err};

        assign o_relay1[g]    = ch.relay1;
        assign o_relay2[g]    = ch.relay2;
        assign o_sup_err[g]   = ch.err;
        assign o_flow_corr[g] = fcorr_ff[g];
        assign o_setpoint[g]  = sp_ff[g];

        fsz_zero u_zero (
            .i_clock (i_clock),
            .i_rst   (i_rst),
            .ch      (ch.zro)
        );

        fsz_supervise #(
            .HOLD (HOLD)
        ) u_sup (
            .i_clock (i_clock),
            .i_rst   (i_rst),
            .ch      (ch.sup)
        );
    end

    assign o_avs_readdata    = rdata_ff;
    assign o_avs_waitrequest = wait_ff;
endmodule

// [hw/fsz_zero.sv]
// offset measurement engine: averages raw flow and judges the result
`timescale 1ns/1ps
module fsz_zero #(
    parameter int LOG2 = fsz_pkg::ZERO_LOG2
) (
    input  wire logic i_clock,
    input  wire logic i_rst,
    fsz_chan_if.zro   ch
);
    import fsz_pkg::*;

    logic                          busy_ff;
    logic [LOG2-1:0]               cnt_ff;
    logic signed [FLOW_W+LOG2-1:0] acc_ff;
    logic                          vlv_ff;
    logic                          done_ff;
    logic                          rej_ff;
    logic signed [FLOW_W-1:0]      meas_ff;
    logic signed [FLOW_W+LOG2-1:0] nxt_acc;
    logic signed [FLOW_W-1:0]      nxt_meas;

    assign nxt_acc  = acc_ff + (FLOW_W+LOG2)'(ch.flow_raw);
    assign nxt_meas = nxt_acc[FLOW_W+LOG2-1:LOG2];

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            busy_ff <= 1'b0;
            cnt_ff  <= '0;
            acc_ff  <= '0;
            vlv_ff  <= 1'b0;
            done_ff <= 1'b0;
            rej_ff  <= 1'b0;
            meas_ff <= '0;
        end else if (ch.ce) begin
            done_ff <= 1'b0;
            if (ch.zero_start && !busy_ff) begin
                busy_ff <= 1'b1;
                cnt_ff  <= '0;
                acc_ff  <= '0;
                vlv_ff  <= ch.valve_on;
            end else if (busy_ff) begin
                acc_ff <= nxt_acc;
                cnt_ff <= cnt_ff + 1'b1;
                vlv_ff <= vlv_ff | ch.valve_on;
                if (&cnt_ff) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                    meas_ff <= nxt_meas;
                    // flow on during the run spoils the result
                    rej_ff  <= vlv_ff | ch.valve_on | (nxt_meas > ZERO_MAX) | (nxt_meas < -ZERO_MAX);
                end
            end
        end
    end

    assign ch.zero_done   = done_ff;
    assign ch.zero_reject = rej_ff;
    assign ch.zero_meas   = meas_ff;
endmodule

// [sim/fsz_mfc_model.sv]
// behavioural flow controllers: measured flow and valve state, prompt or one cycle late
`timescale 1ns/1ps
module fsz_mfc_model #(
    parameter int N_CH = 4
) (
    input  wire logic                                 i_clock,
    input  wire logic                                 i_slow,
    input  wire logic [N_CH-1:0][fsz_pkg::FLOW_W-1:0] i_flow_cmd,
    input  wire logic [N_CH-1:0]                      i_valve_cmd,
    output logic      [N_CH-1:0][fsz_pkg::FLOW_W-1:0] o_flow_raw,
    output logic      [N_CH-1:0]                      o_valve_on
);
    import fsz_pkg::*;
    logic [N_CH-1:0][FLOW_W-1:0] flow_ff;
    logic [N_CH-1:0]             valve_ff;
    always_ff @(posedge i_clock) begin
        flow_ff  <= i_flow_cmd;
        valve_ff <= i_valve_cmd;
    end
    assign o_flow_raw = i_slow ? flow_ff : i_flow_cmd;
    assign o_valve_on = i_slow ? valve_ff : i_valve_cmd;
endmodule

// [sim/fsz_top_props.sv]
// port checks for the flow supervision block
`timescale 1ns/1ps
module fsz_top_props #(
    parameter int N_CH = 4
) (
    input wire logic            i_clock,
    input wire logic            i_rst,
    input wire logic            i_clk_en,
    input wire logic            i_avs_read,
    input wire logic            i_avs_write,
    input wire logic [N_CH-1:0] i_valve_on,
    input wire logic [31:0]     o_avs_readdata,
    input wire logic            o_avs_waitrequest,
    input wire logic [N_CH-1:0] o_relay1,
    input wire logic [N_CH-1:0] o_relay2,
    input wire logic [N_CH-1:0] o_sup_err
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    sequence s_take;
        (i_avs_read || i_avs_write) && o_avs_waitrequest && i_clk_en;
    endsequence
    sequence s_idle;
        !i_avs_read && !i_avs_write && o_avs_waitrequest && i_clk_en;
    endsequence
    a_bus_answer: assert property (s_take |=> !o_avs_waitrequest)
        else $error("access not answered");
    a_wait_single: assert property (!o_avs_waitrequest && i_clk_en |=> o_avs_waitrequest)
        else $error("answer held too long");
    a_wait_idle: assert property (s_idle |=> o_avs_waitrequest)
        else $error("answer without request");
    a_write_rdata: assert property (i_avs_write && !o_avs_waitrequest |-> o_avs_readdata == 32'h0)
        else $error("write returned data");
    a_rdata_hold: assert property (s_idle |=> $stable(o_avs_readdata))
        else $error("read data moved while idle");
    a_reset_quiet: assert property (@(posedge i_clock) disable iff (1'b0) i_rst && i_clk_en |=>
        o_avs_waitrequest && o_relay1 == '0 && o_relay2 == '0 && o_sup_err == '0)
        else $error("outputs active after reset");
    a_relay2_cause: assert property ((o_relay2 & ~(o_sup_err | $past(o_sup_err))) == '0)
        else $error("relay2 without trip");
    a_relay1_cause: assert property ((o_relay1 & ~(i_valve_on | $past(i_valve_on)
        | $past(i_valve_on, 2) | o_sup_err | $past(o_sup_err))) == '0)
        else $error("relay1 without valve or trip");
endmodule
bind fsz_top fsz_top_props #(.N_CH(N_CH)) u_props (.i_clock(i_clock), .i_rst(i_rst), .i_clk_en(i_clk_en),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_valve_on(i_valve_on), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_relay1(o_relay1), .o_relay2(o_relay2), .o_sup_err(o_sup_err));

// [sim/tb_top.sv]
// self-checking bench for the flow supervision block
`timescale 1ns/1ps
module tb_top;
    import fsz_pkg::*;
    logic                        i_clock, i_rst, clk_en, rd_e, wr_e, slow, wreq;
    logic [ADDR_W-1:0]           adr;
    logic [31:0]                 wd, rdat, q;
    logic [N_CH-1:0][FLOW_W-1:0] fl, raw, corr, setp;
    logic [N_CH-1:0]             vl, vo, r1, r2, er;
    int                          failures, total_checks, sel, re, off[N_CH], lo[N_CH], hi[N_CH], md[N_CH];
    int                          ps[N_CH][N_SET];
    fsz_mfc_model #(.N_CH(N_CH)) mfc (.i_clock(i_clock), .i_slow(slow), .i_flow_cmd(fl), .i_valve_cmd(vl),
        .o_flow_raw(raw), .o_valve_on(vo));
    fsz_top #(.N_CH(N_CH), .HOLD(20)) DUT (.i_clock(i_clock), .i_rst(i_rst), .i_clk_en(clk_en),
        .i_avs_address(adr), .i_avs_read(rd_e), .i_avs_write(wr_e), .i_avs_writedata(wd),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_flow_raw(raw), .i_valve_on(vo),
        .o_flow_corr(corr), .o_setpoint(setp), .o_relay1(r1), .o_relay2(r2), .o_sup_err(er));
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic acc(input int a, input logic w, input int d);
        int n;
        n = 0;
        @(posedge i_clock);
        adr <= a[ADDR_W-1:0];
        rd_e <= !w;
        wr_e <= w;
        wd <= d;
        do begin
            @(posedge i_clock);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        q = rdat;
        rd_e <= 1'b0;
        wr_e <= 1'b0;
        if (n >= 50) failures++;
    endtask
    function automatic int ca(int c, int r);
        return ((c + 1) * 16 + r) * 4;
    endfunction
    // expected {relay2, relay1, error} of one channel
    function automatic logic [2:0] ex(int c);
        int f, a, b;
        logic lw, hg;
        f = $signed(fl[c]) - off[c];
        a = (md[c] == 2) ? ps[c][sel] - lo[c] : lo[c];
        b = (md[c] == 2) ? ps[c][sel] + hi[c] : hi[c];
        lw = md[c] != 0 && f < a;
        hg = md[c] != 0 && f > b;
        if (md[c] == 1) return {hg && re != 0, lw && re != 0, lw || hg};
        return {(lw || hg) && re != 0, vl[c] && re != 0, lw || hg};
    endfunction
    task automatic supchk();
        repeat (5) @(posedge i_clock);
        for (int c = 0; c < N_CH; c++) chk({r2[c], r1[c], er[c]}, ex(c));
    endtask
    task automatic zrun(input int e);
        int n;
        n = 0;
        acc(ca(0, 0), 1, 0);
        acc(ca(0, 0), 1, 1);
        do begin
            acc(ca(0, 0), 0, 0);
            n++;
        end while (q < 2 && n < 30);
        chk(q, e);
        if (e == 2) off[0] = $signed(fl[0]);
        acc(ca(0, 1), 0, 0);
        chk(q, off[0]);
    endtask
    task automatic results();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #1000000;
        failures++;
        results();
    end
    initial begin
        void'($urandom(66694));
        {i_rst, clk_en} = 2'b11;
        {rd_e, wr_e, slow, adr, wd, fl, vl} = '0;
        {failures, total_checks, sel, re} = '0;
        repeat (16) @(posedge i_clock);
        i_rst <= 1'b0;
        for (int c = 0; c < N_CH; c++) begin
            for (int r = 0; r < 5; r++) begin
                acc(ca(c, r), 0, 0);
                chk(q, 0);
            end
            {off[c], lo[c], hi[c], md[c]} = '0;
        end
        acc(ca(4, 0), 0, 0);
        chk(q, 0);
        $display("test reset done");
        for (int c = 0; c < N_CH; c++) begin
            off[c] = int'($urandom_range(511)) - 256;
            acc(ca(c, 1), 1, off[c]);
            acc(ca(c, 1), 0, 0);
            chk(q, off[c]);
            for (int p = 0; p < N_SET; p++) begin
                ps[c][p] = int'($urandom_range(4000)) + 1000;
                acc(ca(c, 8 + p), 1, ps[c][p]);
            end
            fl[c] <= 16'($urandom_range(3000));
        end
        for (int s = 0; s < N_SET + 1; s++) begin
            // select 5 is refused, so preset 4 stays active; relays enabled with it
            acc(0, 1, s == N_SET ? 32'h51 : s << 4);
            sel = s == N_SET ? 4 : s;
            repeat (3) @(posedge i_clock);
            for (int c = 0; c < N_CH; c++) begin
                chk(setp[c], 16'(ps[c][sel] + off[c]));
                chk(corr[c], 16'($signed(fl[c]) - off[c]));
            end
        end
        re = 1;
        $display("test offset and presets done");
        slow <= 1'b1;
        fl[0] <= 16'h0123;
        zrun(2);
        fl[0] <= 16'h0300;
        zrun(3);
        fl[0] <= 16'h0050;
        vl[0] <= 1'b1;
        zrun(3);
        vl[0] <= 1'b0;
        fl[0] <= 16'hfe00;
        zrun(2);
        slow <= 1'b0;
        $display("test zero done");
        {lo[1], hi[1], lo[2], hi[2], md[1], md[2]} = {32'd100, 32'd200, 32'd10, 32'd10, 32'd1, 32'd2};
        fl[1] <= 16'(off[1] + 50);
        fl[2] <= 16'(off[2] + ps[2][4] + 30);
        for (int c = 1; c < 3; c++) begin
            acc(ca(c, 2), 1, lo[c]);
            acc(ca(c, 3), 1, hi[c]);
            acc(ca(c, 4), 1, md[c]);
        end
        repeat (2) @(posedge i_clock);
        chk({r2[2:1], r1[1], er[2:1]}, 0);
        repeat (20) @(posedge i_clock);
        for (int i = 0; i < 24; i++) begin
            fl[0] <= 16'($urandom_range(3000));
            fl[3] <= 16'($urandom_range(3000));
            fl[1] <= 16'(off[1] + int'($urandom_range(250, 50)));
            fl[2] <= 16'(off[2] + ps[2][4] + int'($urandom_range(40)) - 20);
            vl <= N_CH'($urandom);
            supchk();
        end
        acc(0, 1, 32'h40);
        re = 0;
        supchk();
        $display("test supervision done");
        results();
    end
endmodule
